// *** design/eep_defs.vh ***
// Purpose: shared constants of the two-wire serial memory slave
// Assumes: core clock of 100 MHz
// Notes: timing counts are in core clock cycles
`ifndef EEP_DEFS_VH
`define EEP_DEFS_VH
`define EEP_CTRL_CODE 4'hA
`define EEP_ADDR_W 13
`define EEP_PAGE_W 5
`define EEP_PAGE_BYTES 32
`define EEP_MEM_BYTES 8192
`define EEP_CLK_MHZ 100
`define EEP_WC_TIME_US 5000
`define EEP_WC_CYCLES (`EEP_WC_TIME_US * `EEP_CLK_MHZ)
`define EEP_FIFO_W 13
`define EEP_FIFO_DEPTH 8
`define EEP_FIFO_AW 3
`endif

// *** design/eep_fifo.v ***
// Purpose: small synchronous fifo with valid and ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes: full and empty are exact; depth must be a power of two
`timescale 1ns/1ps
module eep_fifo #(
   parameter W = 13,
   parameter DEPTH = 8,
   parameter AW = 3
)
(
   input wire core_clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // storage has no reset, only pointers and count do
   always @(posedge core_clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   // pointers wrap naturally at the power-of-two depth
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// *** design/eep_slave.v ***
// Purpose: two-wire serial memory slave, 8K bytes, byte/page write and reads
// Assumes: bus pins sampled by core_clk, bus clock far slower than core_clk
// Notes: write cycle length is a parameter so a bench may shorten it
`timescale 1ns/1ps
`include "eep_defs.vh"
module eep_slave #(
   parameter WC_CYCLES = `EEP_WC_CYCLES
)
(
   input wire core_clk,
   input wire rst_n,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   input wire [2:0] chip_select_pins,
   input wire wp_in,
   output wire busy
);
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_CTRL = 3'd1;
   localparam [2:0] ST_ADRH = 3'd2;
   localparam [2:0] ST_ADRL = 3'd3;
   localparam [2:0] ST_WDAT = 3'd4;
   localparam [2:0] ST_RDAT = 3'd5;

   localparam [1:0] WC_IDLE = 2'd0;
   localparam [1:0] WC_COPY = 2'd1;
   localparam [1:0] WC_WAIT = 2'd2;

   // two-flop synchronisers for every pin
   reg [1:0] scl_s_q;
   reg [1:0] sda_s_q;
   reg [1:0] wp_s_q;
   reg [2:0] cs_m_q;
   reg [2:0] cs_s_q;
   reg scl_d_q;
   reg sda_d_q;

   // protocol state
   reg [2:0] st_q;
   reg [3:0] bitc_q;
   reg [7:0] sh_q;
   reg oe_q;
   reg [4:0] adh_q;
   reg [12:0] ptr_q;
   reg wr_pend_q;
   reg stop_req_q;
   reg wp_lat_q;
   reg clr_page_q;

   // page buffer and write cycle
   reg [7:0] mem_q [0:`EEP_MEM_BYTES-1];
   reg [7:0] page_q [0:`EEP_PAGE_BYTES-1];
   reg [31:0] mask_q;
   reg [1:0] wc_q;
   reg [4:0] cidx_q;
   reg [31:0] wcnt_q;

   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire [7:0] rx_byte;
   wire ctrl_hit;
   wire f_in_ready;
   wire f_out_valid;
   wire f_out_ready;
   wire [12:0] f_out_data;
   wire f_push;
   wire [12:0] f_in_data;
   wire commit_go;

   // low-bit increment inside one page, upper pointer bits untouched
   function [12:0] page_inc;
      input [12:0] a;
      begin
         page_inc = {a[12:5], a[4:0] + 5'h01};
      end
   endfunction

   assign scl_rise = scl_s_q[1] & ~scl_d_q;
   assign scl_fall = ~scl_s_q[1] & scl_d_q;
   assign start_det = scl_s_q[1] & scl_d_q & sda_d_q & ~sda_s_q[1];
   assign stop_det = scl_s_q[1] & scl_d_q & ~sda_d_q & sda_s_q[1];
   assign rx_byte = sh_q;
   // match code and chip select; refused while the cycle runs
   assign ctrl_hit = (rx_byte[7:4] == `EEP_CTRL_CODE) && (rx_byte[3:1] == cs_s_q) &&
      (wc_q == WC_IDLE);
   assign busy = (wc_q != WC_IDLE);
   // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = oe_q;
   assign f_push = (st_q == ST_WDAT) && scl_fall && (bitc_q == 4'd7);
   assign f_in_data = {ptr_q[4:0], rx_byte};

   // pins cross into the core clock through two flops
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_s_q <= 2'b11;
         sda_s_q <= 2'b11;
         wp_s_q <= 2'b00;
         cs_m_q <= 3'h0;
         cs_s_q <= 3'h0;
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end
      else
      begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         wp_s_q <= {wp_s_q[0], wp_in};
         cs_m_q <= chip_select_pins;
         cs_s_q <= cs_m_q;
         scl_d_q <= scl_s_q[1];
         sda_d_q <= sda_s_q[1];
      end
   end

   // byte-level protocol engine; acts on bus clock edges and start/stop
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= ST_IDLE;
         bitc_q <= 4'd0;
         sh_q <= 8'h00;
         oe_q <= 1'b0;
         adh_q <= 5'h00;
         ptr_q <= 13'h0000;
         wr_pend_q <= 1'b0;
         stop_req_q <= 1'b0;
         wp_lat_q <= 1'b0;
         clr_page_q <= 1'b0;
      end
      else
      begin
         clr_page_q <= 1'b0;
         if (commit_go)
            stop_req_q <= 1'b0;
         if (start_det)
         begin
            // repeated start ends a dummy write without touching the pointer
            st_q <= ST_CTRL;
            bitc_q <= 4'hF; // the start's own clock fall wraps it to zero
            oe_q <= 1'b0;
            wr_pend_q <= 1'b0;
         end
         else if (stop_det)
         begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
            bitc_q <= 4'd0;
            wr_pend_q <= 1'b0;
            if (wr_pend_q)
            begin
               stop_req_q <= 1'b1;
               wp_lat_q <= wp_s_q[1];
            end
         end
         else if (st_q == ST_RDAT)
         begin
            // our own ack of the control byte is not a master ack
            if (scl_rise && bitc_q == 4'd8 && !oe_q)
            begin
               // every sent byte advances the pointer, 13-bit wrap included
               ptr_q <= ptr_q + 13'h0001;
               if (sda_s_q[1])
                  st_q <= ST_IDLE;
            end
            else if (scl_fall)
            begin
               if (bitc_q == 4'd8)
               begin
                  // fetch the byte at the pointer and drive its msb
                  sh_q <= {mem_q[ptr_q][6:0], 1'b0};
                  oe_q <= ~mem_q[ptr_q][7];
                  bitc_q <= 4'd0;
               end
               else if (bitc_q == 4'd7)
               begin
                  oe_q <= 1'b0; // release for master ack
                  bitc_q <= 4'd8;
               end
               else
               begin
                  oe_q <= ~sh_q[7];
                  sh_q <= {sh_q[6:0], 1'b0};
                  bitc_q <= bitc_q + 4'd1;
               end
            end
         end
         else if (st_q != ST_IDLE)
         begin
            if (scl_rise && bitc_q < 4'd8)
               sh_q <= {sh_q[6:0], sda_s_q[1]};
            else if (scl_fall && bitc_q == 4'd8)
            begin
               oe_q <= 1'b0; // ack slot over
               bitc_q <= 4'd0;
            end
            else if (scl_fall && bitc_q == 4'd7)
            begin
               bitc_q <= 4'd8;
               case (st_q)
                  ST_CTRL:
                  begin
                     if (ctrl_hit)
                     begin
                        oe_q <= 1'b1;
                        st_q <= rx_byte[0] ? ST_RDAT : ST_ADRH;
                     end
                     else
                        st_q <= ST_IDLE;
                  end
                  ST_ADRH:
                  begin
                     adh_q <= rx_byte[4:0];
                     oe_q <= 1'b1;
                     st_q <= ST_ADRL;
                  end
                  ST_ADRL:
                  begin
                     ptr_q <= {adh_q, rx_byte};
                     oe_q <= 1'b1;
                     clr_page_q <= 1'b1;
                     st_q <= ST_WDAT;
                  end
                  ST_WDAT:
                  begin
                     // a full fifo refuses the byte with a nack
                     if (f_in_ready)
                     begin
                        oe_q <= 1'b1;
                        ptr_q <= page_inc(ptr_q);
                        wr_pend_q <= 1'b1;
                     end
                     else
                        st_q <= ST_IDLE;
                  end
                  default:
                     st_q <= ST_IDLE;
               endcase
            end
            else if (scl_fall)
               bitc_q <= bitc_q + 4'd1;
         end
      end
   end

   // received bytes queue up before landing in the page buffer
   eep_fifo #(
      .W(`EEP_FIFO_W),
      .DEPTH(`EEP_FIFO_DEPTH),
      .AW(`EEP_FIFO_AW)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(f_push),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   // drain stalls during the write cycle; buffer is frozen while it commits
   assign f_out_ready = (wc_q == WC_IDLE);
   // commit waits until every queued byte has reached the buffer
   assign commit_go = stop_req_q && !f_out_valid && (wc_q == WC_IDLE);

   // page buffer fill; later bytes at the same slot overwrite earlier ones
   always @(posedge core_clk)
   begin
      if (f_out_valid && f_out_ready)
         page_q[f_out_data[12:8]] <= f_out_data[7:0];
   end

   // array writes happen only in the copy phase of the cycle
   always @(posedge core_clk)
   begin
      if (wc_q == WC_COPY && mask_q[cidx_q])
         mem_q[{ptr_q[12:5], cidx_q}] <= page_q[cidx_q];
   end

   // self-timed write cycle: copy marked slots, then hold busy for the rest
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mask_q <= 32'h00000000;
         wc_q <= WC_IDLE;
         cidx_q <= 5'h00;
         wcnt_q <= 32'h00000000;
      end
      else
      begin
         if (clr_page_q)
            mask_q <= 32'h00000000;
         else if (f_out_valid && f_out_ready)
            mask_q[f_out_data[12:8]] <= 1'b1;
         case (wc_q)
            WC_IDLE:
            begin
               if (commit_go)
               begin
                  if (wp_lat_q)
                     mask_q <= 32'h00000000;
                  else
                  begin
                     wc_q <= WC_COPY;
                     cidx_q <= 5'h00;
                     wcnt_q <= 32'h00000000;
                  end
               end
            end
            WC_COPY:
            begin
               wcnt_q <= wcnt_q + 32'd1;
               cidx_q <= cidx_q + 5'h01;
               if (cidx_q == 5'h1F)
                  wc_q <= WC_WAIT;
            end
            WC_WAIT:
            begin
               wcnt_q <= wcnt_q + 32'd1;
               if (wcnt_q >= WC_CYCLES - 1)
               begin
                  wc_q <= WC_IDLE;
                  mask_q <= 32'h00000000;
               end
            end
            default:
               wc_q <= WC_IDLE;
         endcase
      end
   end
endmodule

// *** test/eep_slave_checker.sv ***
// Purpose: port-level checks of the two-wire memory slave
// Assumes: one clock domain, asynchronous active-low reset
// Notes: write cycle bound scales with WC_CYCLES
`timescale 1ns/1ps
module eep_slave_checker #(
   parameter int WC_CYCLES = 200
)
(
   input wire core_clk,
   input wire rst_n,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire [2:0] chip_select_pins,
   input wire wp_in,
   input wire busy
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   int unsigned len_q;
   // length of the current write cycle in core clocks
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         len_q <= 0;
      else
         len_q <= busy ? len_q + 1 : 0;
   end
   AST_OPEN_DRAIN: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("data pin driven high");
   AST_SILENT_BUSY: assert property (busy |-> !sda_oe)
      else $error("data pin driven during write cycle");
   AST_BUSY_LEN: assert property ($fell(busy) |->
      len_q >= WC_CYCLES - 1 && len_q <= WC_CYCLES + 4)
      else $error("write cycle length off");
   AST_OE_CHANGE_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data pin changed while bus clock high");
   AST_BUSY_AFTER_STOP: assert property ($rose(busy) |-> scl_in && sda_in)
      else $error("write cycle began outside idle bus");
   AST_WP_BLOCKS: assert property ($rose(busy) |-> !$past(wp_in, 4))
      else $error("write cycle began while protected");
   AST_BUSY_HOLD: assert property ($rose(busy) |=> busy [*8])
      else $error("write cycle ended too soon");
   AST_RESET_IDLE: assert property ($rose(rst_n) |-> !busy && !sda_oe)
      else $error("not idle after reset");
endmodule

// *** test/eep_master_model.sv ***
// Purpose: two-wire bus master facing the memory slave
// Assumes: open-drain data line with pull-up resolved by the bench
// Notes: bus clock stands high between frames; 80 ns period
`timescale 1ns/1ps
module eep_master_model (
   input wire core_clk,
   input wire sda,
   output logic scl,
   output logic m_oe
);
   // idle bus: both lines high
   initial
   begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   task automatic half;
      repeat (4) @(negedge core_clk);
   endtask
   // data moves mid-low, never near an edge, so no false start or stop
   task automatic bit_io(input logic d, output logic s);
      m_oe = ~d;
      repeat (2) @(negedge core_clk);
      scl = 1'b1;
      half;
      s = sda;
      scl = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask
   // start or repeated start
   task automatic start;
      m_oe = 1'b0;
      repeat (2) @(negedge core_clk);
      scl = 1'b1;
      half;
      m_oe = 1'b1;
      half;
      scl = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask
   task automatic stop;
      m_oe = 1'b1;
      repeat (2) @(negedge core_clk);
      scl = 1'b1;
      half;
      m_oe = 1'b0;
      repeat (8) @(negedge core_clk);
   endtask
   // msb first, ninth clock returns the slave's acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   // acknowledge asks for more, withheld acknowledge ends the read
   task automatic recv(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(~more, s);
   endtask
endmodule

// *** test/eep_slave_test.sv ***
// Purpose: self-checking bench of the two-wire memory slave
// Assumes: chip select normally 101, write cycle shortened to 200 clocks
// Notes: expectations follow from the addressing and page rules
`timescale 1ns/1ps
module eep_slave_test;
   localparam int WC = 200;
   localparam logic [7:0] CW = 8'hAA;
   localparam logic [7:0] CR = 8'hAB;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp_in = 1'b0;
   logic [2:0] cs_pins = 3'h5;
   logic scl, m_oe, sda_out, sda_oe, busy, a;
   logic [7:0] d;
   int failures = 0;
   int num_checks = 0;
   // open drain with pull-up
   wire sda = m_oe ? 1'b0 : (sda_oe ? sda_out : 1'b1);
   always #5 core_clk = ~core_clk;
   eep_slave #(.WC_CYCLES(WC)) eep_slave_i (.core_clk(core_clk), .rst_n(rst_n),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .chip_select_pins(cs_pins), .wp_in(wp_in), .busy(busy));
   eep_master_model eep_master_model_i (.core_clk(core_clk), .sda(sda), .scl(scl),
      .m_oe(m_oe));
   task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tx(input logic [7:0] b, input logic e);
      eep_master_model_i.send(b, a);
      check8("ack", {7'h0, e}, {7'h0, a});
   endtask
   task automatic set_ptr(input logic [15:0] ad);
      eep_master_model_i.start;
      tx(CW, 1'b1);
      tx(ad[15:8], 1'b1);
      tx(ad[7:0], 1'b1);
   endtask
   // bounded acknowledge polling; returns attempts taken
   task automatic poll(output int n);
      n = 0;
      do
      begin
         eep_master_model_i.start;
         eep_master_model_i.send(CW, a);
         n++;
      end
      while (!a && n < 50);
      check8("poll_ack", 8'h01, {7'h0, a});
      eep_master_model_i.stop;
   endtask
   task automatic rd(input bit cur, input logic [15:0] ad, input logic [7:0] q[$]);
      if (!cur)
         set_ptr(ad);
      eep_master_model_i.start;
      tx(CR, 1'b1);
      foreach (q[i])
      begin
         eep_master_model_i.recv(i < q.size() - 1, d);
         check8("rdata", q[i], d);
      end
      eep_master_model_i.stop;
   endtask
   // a changed strap must move the device to the matching select code
   task automatic s_select;
      eep_master_model_i.start;
      tx(8'hA2, 1'b0);
      eep_master_model_i.start;
      tx(8'hBA, 1'b0);
      eep_master_model_i.stop;
      cs_pins = 3'h1;
      eep_master_model_i.start;
      tx(8'hA2, 1'b1);
      eep_master_model_i.stop;
      cs_pins = 3'h5;
   endtask
   // protect raised mid-cycle must not cancel the write
   task automatic s_byte;
      int n;
      set_ptr(16'hFFFF);
      tx(8'h5A, 1'b1);
      eep_master_model_i.stop;
      wp_in = 1'b1;
      check8("busy", 8'h01, {7'h0, busy});
      poll(n);
      check8("nacked", 8'h01, {7'h0, n > 1});
      wp_in = 1'b0;
      set_ptr(16'h0000);
      tx(8'hA5, 1'b1);
      eep_master_model_i.stop;
      poll(n);
      rd(0, 16'h1FFF, '{8'h5A, 8'hA5});
   endtask
   // 34 bytes from slot 3E wrap the page and overwrite slots 3E and 3F
   task automatic s_page;
      int n;
      logic [7:0] q[$];
      set_ptr(16'h0C3E);
      for (int i = 0; i < 34; i++)
         tx(8'(i), 1'b1);
      eep_master_model_i.stop;
      poll(n);
      for (int k = 0; k < 31; k++)
         q.push_back(8'(k < 30 ? k + 2 : 32));
      rd(0, 16'h0C20, q);
      rd(1, 16'h0, '{8'h21});
   endtask
   task automatic s_ptr;
      int n;
      set_ptr(16'h0C30);
      tx(8'h77, 1'b1);
      eep_master_model_i.stop;
      poll(n);
      rd(1, 16'h0, '{8'h13});
   endtask
   task automatic s_prot;
      int n;
      wp_in = 1'b1;
      set_ptr(16'h0C31);
      tx(8'hEE, 1'b1);
      tx(8'hEF, 1'b1);
      eep_master_model_i.stop;
      check8("busy", 8'h00, {7'h0, busy});
      poll(n);
      check8("polls", 8'h01, 8'(n));
      wp_in = 1'b0;
      rd(0, 16'h0C31, '{8'h13, 8'h14});
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      s_select;
      s_byte;
      s_page;
      s_ptr;
      s_prot;
      end_sim;
   end
   // watchdog, a few times the expected run
   initial
   begin
      #500000;
      failures++;
      end_sim;
   end
endmodule
bind eep_slave eep_slave_checker #(.WC_CYCLES(WC_CYCLES)) eep_slave_checker_i (
   .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(chip_select_pins),
   .wp_in(wp_in), .busy(busy));
